// file: bench/prog_mem_model.sv
/*
  Byte-addressed program memory model with fixed, address-derived contents.
  Assumes the unit holds prog_addr while prog_rd stands.
*/
`timescale 1ns/1ps
module prog_mem_model
(
  input wire logic [20:0] prog_addr,
  input wire logic prog_rd,
  output logic [7:0] prog_rd_data
);
  logic [7:0] byte_at;
  // Outside a read the bus carries the inverse, so a late sample cannot match.
  always_comb
  begin
    byte_at = prog_addr[7:0] ^ prog_addr[15:8] ^ {3'h0, prog_addr[20:16]} ^ 8'h5a;
    prog_rd_data = prog_rd ? byte_at : ~byte_at;
  end
endmodule

// file: bench/table_access_and_test_exec_tb.sv
/*
  Self-checking bench for the table access and test/xor execution unit.
  Assumes prog_mem_model stands for program memory; the bench acts as the core.
*/
`timescale 1ns/1ps
module table_access_and_test_exec_tb;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  tblx_pkg::instr_s instr = '0;
  logic [3:0] bank_select_register = 4'h0;
  logic [7:0] data_rd = 8'h00;
  logic [7:0] w_in = 8'h00;
  logic [7:0] latch_load_value = 8'h00;
  logic [2:0] hold_rd_addr = 3'h0;
  logic ptr_load = 1'b0;
  logic latch_load = 1'b0;
  logic [20:0] ptr_load_value = 21'h00_0000;
  tblx_pkg::data_addr_s data_addr;
  tblx_pkg::nz_flags_s flags;
  logic [20:0] prog_addr;
  logic [20:0] table_pointer;
  logic prog_rd, w_write, flags_write, busy, discard;
  logic [7:0] prog_rd_data, table_latch, w_out, hold_rd_data;
  logic [20:0] starts [4] = '{21'h00_a356, 21'h1f_ffff, 21'h00_0000, 21'h1f_ffff};
  logic [20:0] delta [4] = '{21'h00_0000, 21'h00_0001, 21'h1f_ffff, 21'h00_0001};
  int failures = 0;
  int checks_done = 0;

  always #12.5 mclk = ~mclk;

  table_access_and_test_exec dut_u
  (
    .mclk(mclk), .reset(reset), .instr(instr), .bank_select_register(bank_select_register),
    .data_rd(data_rd), .prog_rd_data(prog_rd_data), .hold_rd_addr(hold_rd_addr),
    .ptr_load(ptr_load), .ptr_load_value(ptr_load_value), .latch_load(latch_load),
    .latch_load_value(latch_load_value), .w_in(w_in), .data_addr(data_addr), .prog_addr(prog_addr),
    .prog_rd(prog_rd), .table_pointer(table_pointer), .table_latch(table_latch), .w_out(w_out),
    .w_write(w_write), .flags(flags), .flags_write(flags_write), .busy(busy), .discard(discard),
    .hold_rd_data(hold_rd_data)
  );

  prog_mem_model mem_u
  (
    .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_rd_data(prog_rd_data)
  );

  function automatic logic [7:0] mem(input logic [20:0] a);
    return a[7:0] ^ a[15:8] ^ {3'h0, a[20:16]} ^ 8'h5a;
  endfunction

  task automatic print_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [20:0] got, input logic [20:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Selector 0 watches busy, 1 watches prog_rd, 2 watches w_write.
  task automatic wait_hi(input int sel, output int n);
    logic s;
    n = 0;
    #1;
    s = (sel == 0) ? busy : (sel == 1) ? prog_rd : w_write;
    while (s !== 1'b1 && n < 8)
    begin
      @(posedge mclk);
      #1;
      n++;
      s = (sel == 0) ? busy : (sel == 1) ? prog_rd : w_write;
    end
    if (s !== 1'b1)
    begin
      failures++;
      print_verdict();
    end
  endtask

  task automatic setup(input logic [20:0] p, input logic [7:0] l);
    @(posedge mclk);
    ptr_load <= 1'b1;
    ptr_load_value <= p;
    latch_load <= 1'b1;
    latch_load_value <= l;
    @(posedge mclk);
    ptr_load <= 1'b0;
    latch_load <= 1'b0;
  endtask

  task automatic issue(input logic [15:0] w, input logic two);
    instr <= {1'b1, w, two};
    @(posedge mclk);
    instr <= '0;
  endtask

  task automatic table_op(input logic wr, input logic [1:0] m);
    logic [20:0] a, e;
    tblx_pkg::nz_flags_s f;
    int n;
    e = starts[m] + delta[m];
    a = (m == 2'h3) ? e : starts[m];
    f = flags;
    setup(starts[m], {5'h18, wr, m});
    issue({12'h000, 1'b1, wr, m}, 1'b0);
    wait_hi(0, n);
    check(21'(n), 21'h00_0000);
    if (!wr)
    begin
      wait_hi(1, n);
      check(21'(n), 21'h00_0001);
      check(prog_addr, a);
    end
    repeat (2) @(posedge mclk);
    hold_rd_addr <= a[2:0];
    repeat (2) @(posedge mclk);
    #1;
    check(table_pointer, e);
    check(21'(flags), 21'(f));
    if (wr)
      check(21'(hold_rd_data), {13'h0000, 5'h18, wr, m});
    else
      check(21'(table_latch), 21'(mem(a)));
  endtask

  task automatic xor_case(input logic [7:0] w, input logic [7:0] k);
    logic [7:0] r;
    int n;
    r = w ^ k;
    @(posedge mclk);
    w_in <= w;
    issue({8'h0a, k}, 1'b0);
    wait_hi(2, n);
    check(21'(n), 21'h00_0000);
    check(21'(w_out), 21'(r));
    check(21'(flags_write), 21'h00_0001);
    check(21'(flags), {19'h0_0000, r[7], r == 8'h00});
  endtask

  task automatic tst_case(input logic [7:0] v, input logic a, input logic two);
    int d;
    tblx_pkg::nz_flags_s f;
    d = 0;
    f = flags;
    @(posedge mclk);
    data_rd <= v;
    bank_select_register <= 4'h9;
    issue({7'h33, a, 8'h5c}, two);
    #1;
    check(21'(data_addr), {9'h000, a ? 4'h9 : 4'h0, 8'h5c});
    check(21'(busy), 21'(v == 8'h00 && two));
    repeat (4)
    begin
      d += int'(discard === 1'b1);
      @(posedge mclk);
      #1;
    end
    check(21'(d), (v != 8'h00) ? 21'h00_0000 : two ? 21'h00_0002 : 21'h00_0001);
    check(21'(flags), 21'(f));
  endtask

  initial
  begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    #1;
    check(table_pointer, 21'h00_0000);
    for (int i = 0; i < 8; i++)
      table_op(i[2], i[1:0]);
    xor_case(8'hb5, 8'haf);
    xor_case(8'h5a, 8'h5a);
    xor_case(8'h0f, 8'h80);
    tst_case(8'h00, 1'b0, 1'b0);
    tst_case(8'h00, 1'b1, 1'b1);
    tst_case(8'h01, 1'b1, 1'b0);
    tst_case(8'h80, 1'b0, 1'b1);
    print_verdict();
  end
endmodule

// file: hdl/hold_regs.sv
/*
  Eight byte write holding registers with a registered read port.
  Assumes the flash programming sequence outside reads them to commit.
*/
`timescale 1ns/1ps
module hold_regs
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [2:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [2:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [tblx_pkg::HOLD_N];
  logic [7:0] next_rd_data;

  always_comb
  begin
    next_rd_data = mem[rd_addr];
  end

  genvar i;
  generate
    for (i = 0; i < tblx_pkg::HOLD_N; i++)
    begin : g_hold
      always_ff @(posedge mclk or posedge reset)
      begin
        if (reset)
          mem[i] <= tblx_pkg::BYTE_ZERO;
        else if (wr_en && wr_addr == 3'(i))
          mem[i] <= wr_data; // [RULE16]
      end
    end
  endgenerate

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      rd_data <= tblx_pkg::BYTE_ZERO;
    else
      rd_data <= next_rd_data;
  end
endmodule

// file: hdl/table_access_and_test_exec.sv
/*
  Execution unit for table read, table write, test-skip-zero and literal xor.
  Assumes one instruction per mclk cycle from the fetch stage, a program memory
  that returns a byte in the same cycle as its address, and a data memory with
  combinational read.
*/
`timescale 1ns/1ps
module table_access_and_test_exec
(
  input wire logic mclk,
  input wire logic reset,
  input wire tblx_pkg::instr_s instr,
  input wire logic [3:0] bank_select_register,
  input wire logic [7:0] data_rd,
  input wire logic [7:0] prog_rd_data,
  input wire logic [2:0] hold_rd_addr,
  input wire logic ptr_load,
  input wire logic [20:0] ptr_load_value,
  input wire logic latch_load,
  input wire logic [7:0] latch_load_value,
  input wire logic [7:0] w_in,
  output tblx_pkg::data_addr_s data_addr,
  output logic [20:0] prog_addr,
  output logic prog_rd,
  output logic [20:0] table_pointer,
  output logic [7:0] table_latch,
  output logic [7:0] w_out,
  output logic w_write,
  output tblx_pkg::nz_flags_s flags,
  output logic flags_write,
  output logic busy,
  output logic discard,
  output logic [7:0] hold_rd_data
);
  typedef enum logic [1:0] {IDLE, TBL_RD2, TBL_WR2, SKIP2} state_e;

  state_e state, next_state;
  logic [20:0] next_table_pointer, next_prog_addr, xfer_ptr;
  logic [7:0] next_table_latch, next_w_out, xr;
  logic next_prog_rd, next_w_write, next_flags_write, next_busy, next_discard;
  logic hold_we, next_hold_we;
  logic [2:0] hold_wa, next_hold_wa;
  logic [1:0] mode, next_mode;
  logic extra_skip, next_extra_skip;
  tblx_pkg::nz_flags_s next_flags;
  tblx_pkg::data_addr_s next_data_addr;
  logic is_rd, is_wr, is_tst, is_xor;

  always_comb
  begin
    is_rd = instr.valid && instr.word[15:4] == tblx_pkg::TBL_HI
            && instr.word[3:2] == tblx_pkg::TBL_RD_SEL; // [RULE1]
    is_wr = instr.valid && instr.word[15:4] == tblx_pkg::TBL_HI
            && instr.word[3:2] == tblx_pkg::TBL_WR_SEL; // [RULE6]
    is_tst = instr.valid && instr.word[15:9] == tblx_pkg::TST_HI; // [RULE10]
    is_xor = instr.valid && instr.word[15:8] == tblx_pkg::XOR_HI; // [RULE14]
    xr = w_in ^ instr.word[7:0];
    // Pre-increment uses the bumped pointer for the access itself.
    xfer_ptr = (mode == tblx_pkg::MODE_PRE_INC) ? table_pointer + tblx_pkg::PTR_ONE : table_pointer; // [RULE3]
    next_state = state;
    next_table_pointer = table_pointer;
    next_table_latch = table_latch;
    next_prog_addr = prog_addr;
    next_prog_rd = 1'b0;
    next_w_out = w_out;
    next_w_write = 1'b0;
    next_flags = flags;
    next_flags_write = 1'b0;
    next_busy = 1'b0;
    next_discard = 1'b0;
    next_hold_we = 1'b0;
    next_hold_wa = hold_wa;
    next_mode = mode;
    next_extra_skip = extra_skip;
    next_data_addr = data_addr;
    if (ptr_load)
      next_table_pointer = ptr_load_value;
    if (latch_load)
      next_table_latch = latch_load_value;
    case (state)
      IDLE:
      begin
        if (is_rd || is_wr)
        begin
          next_mode = instr.word[1:0];
          next_busy = 1'b1; // [RULE8]
          next_state = is_rd ? TBL_RD2 : TBL_WR2;
        end
        else if (is_tst)
        begin
          next_data_addr.offset = instr.word[7:0];
          next_data_addr.bank = instr.word[8] ? bank_select_register : tblx_pkg::BANK_ACCESS; // [RULE13]
          if (data_rd == tblx_pkg::BYTE_ZERO)
          begin
            next_discard = 1'b1; // [RULE11]
            next_busy = instr.next_two_word;
            next_extra_skip = instr.next_two_word; // [RULE12]
            next_state = instr.next_two_word ? SKIP2 : IDLE;
          end
        end
        else if (is_xor)
        begin
          next_w_out = xr;
          next_w_write = 1'b1;
          next_flags.negative = xr[7]; // [RULE15]
          next_flags.zero = xr == tblx_pkg::BYTE_ZERO; // [RULE15]
          next_flags_write = 1'b1;
        end
      end
      TBL_RD2:
      begin
        next_prog_addr = xfer_ptr; // [RULE2] [RULE4] [RULE5]
        next_prog_rd = 1'b1;
        next_state = IDLE;
      end
      TBL_WR2:
      begin
        next_hold_wa = xfer_ptr[2:0]; // [RULE7]
        next_hold_we = 1'b1;
        next_state = IDLE;
      end
      SKIP2:
      begin
        next_discard = 1'b1; // [RULE12]
        next_extra_skip = 1'b0;
        next_state = IDLE;
      end
      default:
        next_state = IDLE;
    endcase
    if (state == TBL_RD2 || state == TBL_WR2)
    begin
      case (mode)
        tblx_pkg::MODE_POST_INC: next_table_pointer = table_pointer + tblx_pkg::PTR_ONE; // [RULE3]
        tblx_pkg::MODE_POST_DEC: next_table_pointer = table_pointer - tblx_pkg::PTR_ONE; // [RULE3]
        tblx_pkg::MODE_PRE_INC: next_table_pointer = xfer_ptr; // [RULE3]
        default: next_table_pointer = table_pointer;
      endcase
    end
    if (prog_rd)
      next_table_latch = prog_rd_data; // [RULE2]
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      state <= IDLE;
      table_pointer <= tblx_pkg::PTR_RESET;
      table_latch <= tblx_pkg::BYTE_ZERO;
      prog_addr <= tblx_pkg::PTR_RESET;
      prog_rd <= 1'b0;
      w_out <= tblx_pkg::BYTE_ZERO;
      w_write <= 1'b0;
      flags <= '0;
      flags_write <= 1'b0; // [RULE9]
      busy <= 1'b0;
      discard <= 1'b0;
      hold_we <= 1'b0;
      hold_wa <= 3'h0;
      mode <= tblx_pkg::MODE_NONE;
      extra_skip <= 1'b0;
      data_addr <= '0;
    end
    else
    begin
      state <= next_state;
      table_pointer <= next_table_pointer;
      table_latch <= next_table_latch;
      prog_addr <= next_prog_addr;
      prog_rd <= next_prog_rd;
      w_out <= next_w_out;
      w_write <= next_w_write;
      flags <= next_flags;
      flags_write <= next_flags_write;
      busy <= next_busy;
      discard <= next_discard;
      hold_we <= next_hold_we;
      hold_wa <= next_hold_wa;
      mode <= next_mode;
      extra_skip <= next_extra_skip;
      data_addr <= next_data_addr;
    end
  end

  hold_regs u_hold
  (
    .mclk(mclk),
    .reset(reset),
    .wr_en(hold_we),
    .wr_addr(hold_wa),
    .wr_data(table_latch),
    .rd_addr(hold_rd_addr),
    .rd_data(hold_rd_data)
  );

  a_rd_two_cycle: assert property (@(posedge mclk) disable iff (reset) // [RULE8]
    (state == IDLE && is_rd) |=> state == TBL_RD2 ##1 prog_rd)
    else $error("table read did not fetch in second cycle");
  a_wr_hold: assert property (@(posedge mclk) disable iff (reset) // [RULE7]
    state == TBL_WR2 |=> hold_we && hold_wa == $past(xfer_ptr[2:0]))
    else $error("table write holding index wrong");
  a_post_inc: assert property (@(posedge mclk) disable iff (reset) // [RULE3]
    (state != IDLE && state != SKIP2 && mode == tblx_pkg::MODE_POST_INC && !ptr_load)
    |=> table_pointer == $past(table_pointer) + tblx_pkg::PTR_ONE)
    else $error("post increment wrong");
  a_post_dec: assert property (@(posedge mclk) disable iff (reset) // [RULE3]
    (state != IDLE && state != SKIP2 && mode == tblx_pkg::MODE_POST_DEC && !ptr_load)
    |=> table_pointer == $past(table_pointer) - tblx_pkg::PTR_ONE)
    else $error("post decrement wrong");
  a_rd_latch: assert property (@(posedge mclk) disable iff (reset) // [RULE2]
    prog_rd |=> table_latch == $past(prog_rd_data))
    else $error("table latch not loaded");
  a_xor_result: assert property (@(posedge mclk) disable iff (reset) // [RULE14]
    (state == IDLE && is_xor) |=> w_write && w_out == ($past(w_in) ^ $past(instr.word[7:0])))
    else $error("literal xor result wrong");
  a_xor_zero: assert property (@(posedge mclk) disable iff (reset) // [RULE15]
    (state == IDLE && is_xor) |=> flags.zero == (w_out == tblx_pkg::BYTE_ZERO) && !busy)
    else $error("xor zero flag wrong");
  a_no_flags: assert property (@(posedge mclk) disable iff (reset) // [RULE9]
    (state == IDLE && (is_rd || is_wr || is_tst)) |=> !flags_write ##1 !flags_write)
    else $error("flags written by table or test op");
  a_skip_two: assert property (@(posedge mclk) disable iff (reset) // [RULE12]
    (state == IDLE && is_tst && data_rd == tblx_pkg::BYTE_ZERO && instr.next_two_word)
    |=> discard ##1 discard)
    else $error("two word skip not two discards");
  a_skip_one: assert property (@(posedge mclk) disable iff (reset) // [RULE11]
    (state == IDLE && is_tst && data_rd == tblx_pkg::BYTE_ZERO && !instr.next_two_word)
    |=> discard && !busy ##1 !discard)
    else $error("one word skip not a single discard");
  a_bank_access: assert property (@(posedge mclk) disable iff (reset) // [RULE13]
    (state == IDLE && is_tst && !instr.word[8]) |=> data_addr.bank == tblx_pkg::BANK_ACCESS)
    else $error("access bank not used");
endmodule

// file: inc/tblx_pkg.sv
/*
  Constants and carrier types for the table access and test/xor execution unit.
  Assumes a core that presents one decoded instruction word per instruction cycle.
*/
// Summary of operation
// (RULE1) Word 0x0008..0x000B is a table read; low two bits pick pointer update.
// (RULE2) Table read fetches the program byte at the pointer into the table latch.
// (RULE3) Mode 0 none, 1 post-increment, 2 post-decrement, 3 pre-increment.
// (RULE4) Table pointer is a 21-bit byte address over 2 Mbyte.
// (RULE5) Pointer bit 0 low selects low byte, high selects high byte.
// (RULE6) Word 0x000C..0x000F is a table write with the same four modes.
// (RULE7) Table write copies the latch into holding register pointer[2:0].
// (RULE8) Table read and write take two cycles, transfer in the second.
// (RULE9) Table ops and test-skip leave status flags alone.
// (RULE10) Top seven bits 0110011 is test-skip-zero; bit 8 bank select, low byte address.
// (RULE11) Zero register discards the prefetched instruction, costing one extra cycle.
// (RULE12) A skipped two-word instruction costs one more idle cycle.
// (RULE13) Bank bit zero uses access bank, one uses bank select register.
// (RULE14) Word 0x0A kk exclusive-ORs literal into the working register.
// (RULE15) Literal xor sets only negative and zero, in one cycle.
// (RULE16) Holding register loads never alter program memory directly.
package tblx_pkg;
  localparam int PTR_W = 21;
  localparam int HOLD_N = 8;
  localparam int HOLD_A = 3;
  localparam logic [11:0] TBL_HI = 12'h000;
  localparam logic [1:0] TBL_RD_SEL = 2'h2;
  localparam logic [1:0] TBL_WR_SEL = 2'h3;
  localparam logic [6:0] TST_HI = 7'h33;
  localparam logic [7:0] XOR_HI = 8'h0a;
  localparam logic [1:0] MODE_NONE = 2'h0;
  localparam logic [1:0] MODE_POST_INC = 2'h1;
  localparam logic [1:0] MODE_POST_DEC = 2'h2;
  localparam logic [1:0] MODE_PRE_INC = 2'h3;
  localparam logic [20:0] PTR_ONE = 21'h00_0001;
  localparam logic [20:0] PTR_RESET = 21'h00_0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [3:0] BANK_ACCESS = 4'h0;
  typedef struct packed {
    logic valid;
    logic [15:0] word;
    logic next_two_word;
  } instr_s;
  typedef struct packed {
    logic [3:0] bank;
    logic [7:0] offset;
  } data_addr_s;
  typedef struct packed {
    logic negative;
    logic zero;
  } nz_flags_s;
endpackage
